// ---- verilog/tcs_pkg.sv ----
package tcs_pkg;

    // word and character geometry
    localparam int WORD_W    = 36;
    localparam int CHAR_W    = 6;
    localparam int ADDR_W    = 15;
    localparam int COUNT_W   = 8;
    localparam int CHARS     = WORD_W / CHAR_W;
    // table word fields: character in S,1-5 (bits 35:30), address in 21-35 (bits 14:0)
    localparam int TBL_CHAR_LSB = 30;
    localparam int TBL_ADDR_LSB = 0;
    localparam int MSB_CHAR_LSB = 30;
    localparam int LSB_CHAR_LSB = 0;
    // index register numbers
    localparam logic [2:0] XR_CONVERT = 3'h1;
    localparam logic [2:0] XR_LINK    = 3'h4;
    localparam logic [WORD_W-1:0] WORD_RESET = 36'h0_0000_0000;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 15'h0000;

    typedef enum logic [2:0] {
        TCS_OP_REPLACE_RIGHT,   // convert_replace_rightward
        TCS_OP_REPLACE_LEFT,    // convert_replace_quotient_leftward
        TCS_OP_ADD_QUOTIENT,    // convert_add_from_quotient
        TCS_OP_TRANSFER_SET,    // transfer_and_set_index
        TCS_OP_EFF_ADDR
    } tcs_op_t;

    typedef struct packed {
        tcs_op_t            op;
        logic [ADDR_W-1:0]  addr;
        logic [2:0]         tag;
        logic [COUNT_W-1:0] count;
        logic [ADDR_W-1:0]  location;
    } tcs_cmd_t;

    typedef struct packed {
        logic              req;
        logic [ADDR_W-1:0] addr;
    } tcs_mem_req_t;

    typedef struct packed {
        logic              we;
        logic [2:0]        sel;
        logic [ADDR_W-1:0] value;
    } tcs_xr_write_t;

endpackage

// ---- verilog/tcs_char_unit.sv ----
`timescale 1ns/1ns
// picks the working character and forms the next source word and table address
module tcs_char_unit
    import tcs_pkg::*;
(
    // operation
    input  wire logic              i_from_right,
    input  wire logic [WORD_W-1:0] i_word,
    input  wire logic [ADDR_W-1:0] i_base,
    input  wire logic [CHAR_W-1:0] i_repl,
    // results
    output logic      [CHAR_W-1:0] o_char,
    output logic      [ADDR_W-1:0] o_table_addr,
    output logic      [WORD_W-1:0] o_replaced
);
    always_comb begin
        if (i_from_right) begin
            o_char     = i_word[LSB_CHAR_LSB +: CHAR_W];
            // replace low char, rotate right so the next char lands low
            o_replaced = {i_repl, i_word[WORD_W-1:CHAR_W]};
        end else begin
            o_char     = i_word[MSB_CHAR_LSB +: CHAR_W];
            o_replaced = {i_word[WORD_W-CHAR_W-1:0], i_repl};
        end
        // 15-bit wrap is intentional: core addresses are modulo storage size
        o_table_addr = i_base + ADDR_W'(o_char);
    end
endmodule

// ---- verilog/tcs_sequencer.sv ----
`timescale 1ns/1ns
// Operation
// - the 36-bit source word is handled as six 6-bit characters in turn.
// - replace-right steps accumulator characters from least to most significant.
// - replace-left steps quotient characters from most to least significant.
// - replacing converts leave converted characters in the source register.
// - add convert scans quotient leftward, adding each fetched table word into accumulator.
// - converts work through core storage, accumulator, quotient and storage registers.
// - on request, index register 1 gets result information at convert end.
// - transfer-and-set-index puts two's complement of its location into index 4.
// - effective address is address field minus selected index register contents.
// - each table reference is at current base plus current character value.
// - table word gives replacement from S,1-5 and next base from 21-35.
// - count decrements per character; convert ends when count reaches zero.
// - with tag 1, last table word address part goes to index 1.
module tcs_sequencer
    import tcs_pkg::*;
(
    // clock and control
    input  wire logic              i_clk,
    input  wire logic              i_rst,
    input  wire logic              i_ce,
    // command
    input  wire logic              i_start,
    input  wire tcs_cmd_t          i_cmd,
    input  wire logic [ADDR_W-1:0] i_xr_value,
    output logic                   o_busy,
    output logic                   o_done,
    // register load
    input  wire logic              i_load,
    input  wire logic [WORD_W-1:0] i_acc_load,
    input  wire logic [WORD_W-1:0] i_mq_load,
    // core storage
    output tcs_mem_req_t           o_mem,
    input  wire logic              i_mem_valid,
    input  wire logic [WORD_W-1:0] i_mem_data,
    // results
    output logic      [WORD_W-1:0] o_accumulator_register,
    output logic      [WORD_W-1:0] o_multiplier_quotient_register,
    output logic      [WORD_W-1:0] o_storage_register,
    output logic      [ADDR_W-1:0] o_eff_addr,
    output logic      [ADDR_W-1:0] o_transfer_addr,
    output tcs_xr_write_t          o_xr_write
);
    typedef enum logic [1:0] {
        TCS_IDLE,
        TCS_FETCH,
        TCS_WAIT,
        TCS_FINISH
    } tcs_state_t;

    typedef struct packed {
        tcs_state_t         state;
        tcs_op_t            op;
        logic [2:0]         tag;
        logic [COUNT_W-1:0] count;
        logic [ADDR_W-1:0]  base;
        logic [WORD_W-1:0]  acc;
        logic [WORD_W-1:0]  mq;
        logic [WORD_W-1:0]  sr;
        logic               mem_req;
        logic [ADDR_W-1:0]  mem_addr;
        logic               done;
        logic [ADDR_W-1:0]  eff_addr;
        logic [ADDR_W-1:0]  transfer_addr;
        tcs_xr_write_t      xr_write;
    } tcs_regs_t;

    localparam tcs_regs_t REGS_RESET = '{
        state:         TCS_IDLE,
        op:            TCS_OP_REPLACE_RIGHT,
        tag:           3'h0,
        count:         '0,
        base:          ADDR_RESET,
        acc:           WORD_RESET,
        mq:            WORD_RESET,
        sr:            WORD_RESET,
        mem_req:       1'b0,
        mem_addr:      ADDR_RESET,
        done:          1'b0,
        eff_addr:      ADDR_RESET,
        transfer_addr: ADDR_RESET,
        xr_write:      '0
    };

    tcs_regs_t         state_reg;
    tcs_regs_t         state_next;
    logic              from_right;
    logic [WORD_W-1:0] src_word;
    logic [CHAR_W-1:0] cur_char;
    logic [ADDR_W-1:0] table_addr;
    logic [WORD_W-1:0] replaced;
    logic [CHAR_W-1:0] repl_char;

    // the three table-driven converts; other codes never start a table walk
    function automatic logic is_convert(input tcs_op_t op);
        is_convert = (op == TCS_OP_REPLACE_RIGHT) || (op == TCS_OP_REPLACE_LEFT) ||
                     (op == TCS_OP_ADD_QUOTIENT);
    endfunction

    // only the replace-right convert takes its characters from the accumulator
    assign from_right = (state_reg.op == TCS_OP_REPLACE_RIGHT);
    assign src_word   = from_right ? state_reg.acc : state_reg.mq;
    assign repl_char  = i_mem_data[TBL_CHAR_LSB +: CHAR_W];

    tcs_char_unit u_char (
        .i_from_right (from_right),
        .i_word       (src_word),
        .i_base       (state_reg.base),
        .i_repl       (repl_char),
        .o_char       (cur_char),
        .o_table_addr (table_addr),
        .o_replaced   (replaced)
    );

    always_comb begin
        state_next = state_reg;
        state_next.mem_req  = 1'b0;
        state_next.done     = 1'b0;
        state_next.xr_write = '0;
        case (state_reg.state)
            TCS_IDLE: begin
                // loads only land while idle, so a running convert keeps its operands
                if (i_load) begin
                    state_next.acc = i_acc_load;
                    state_next.mq  = i_mq_load;
                end
                if (i_start) begin
                    state_next.op    = i_cmd.op;
                    state_next.tag   = i_cmd.tag;
                    state_next.count = i_cmd.count;
                    state_next.base  = i_cmd.addr;
                    if (i_cmd.op == TCS_OP_TRANSFER_SET) begin
                        // two's complement of own location, then branch to address
                        state_next.xr_write.we    = 1'b1;
                        state_next.xr_write.sel   = XR_LINK;
                        state_next.xr_write.value = ADDR_W'(~i_cmd.location + 1'b1);
                        state_next.transfer_addr  = i_cmd.addr;
                        state_next.done           = 1'b1;
                    end else if (i_cmd.op == TCS_OP_EFF_ADDR) begin
                        // subtracting a stored complement adds back the location
                        state_next.eff_addr = (i_cmd.tag == 3'h0) ? i_cmd.addr :
                                              ADDR_W'(i_cmd.addr - i_xr_value);
                        state_next.done     = 1'b1;
                    end else if (is_convert(i_cmd.op)) begin
                        // undefined codes never reach this branch and leave the block idle
                        if (i_cmd.count == '0) begin
                            state_next.state = TCS_FINISH;
                        end else begin
                            state_next.state = TCS_FETCH;
                        end
                    end
                end
            end
            TCS_FETCH: begin
                // address from current base and working character
                state_next.mem_req  = 1'b1;
                state_next.mem_addr = table_addr;
                state_next.state    = TCS_WAIT;
            end
            TCS_WAIT: begin
                // answers seen in any other state are dropped
                if (i_mem_valid) begin
                    state_next.sr   = i_mem_data;
                    state_next.base = i_mem_data[TBL_ADDR_LSB +: ADDR_W];
                    case (state_reg.op)
                        TCS_OP_REPLACE_RIGHT: begin
                            state_next.acc = replaced;
                        end
                        TCS_OP_REPLACE_LEFT: begin
                            state_next.mq = replaced;
                        end
                        TCS_OP_ADD_QUOTIENT: begin
                            // logical add, carries out of bit 35 are lost
                            state_next.acc = state_reg.acc + i_mem_data;
                            state_next.mq  = {state_reg.mq[WORD_W-CHAR_W-1:0],
                                              state_reg.mq[WORD_W-1 -: CHAR_W]};
                        end
                        default: begin
                            state_next.acc = state_reg.acc;
                        end
                    endcase
                    state_next.count = state_reg.count - 1'b1;
                    state_next.state = (state_reg.count == COUNT_W'(1)) ? TCS_FINISH : TCS_FETCH;
                end
            end
            TCS_FINISH: begin
                // a zero count references no table word, so the previous address is written
                if (state_reg.tag == XR_CONVERT) begin
                    state_next.xr_write.we    = 1'b1;
                    state_next.xr_write.sel   = XR_CONVERT;
                    state_next.xr_write.value = state_reg.sr[TBL_ADDR_LSB +: ADDR_W];
                end
                state_next.done  = 1'b1;
                state_next.state = TCS_IDLE;
            end
            default: begin
                state_next.state = TCS_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_reg <= REGS_RESET;
        end else if (i_ce) begin
            state_reg <= state_next;
        end
    end

    assign o_busy                         = (state_reg.state != TCS_IDLE);
    assign o_done                         = state_reg.done;
    assign o_mem.req                      = state_reg.mem_req;
    assign o_mem.addr                     = state_reg.mem_addr;
    assign o_accumulator_register         = state_reg.acc;
    assign o_multiplier_quotient_register = state_reg.mq;
    assign o_storage_register             = state_reg.sr;
    assign o_eff_addr                     = state_reg.eff_addr;
    assign o_transfer_addr                = state_reg.transfer_addr;
    assign o_xr_write                     = state_reg.xr_write;
endmodule

// ---- sim/tcs_core_model.sv ----
`timescale 1ns/1ns
// conversion table store; answers one or five cycles after a request
module tcs_core_model
    import tcs_pkg::*;
(
    // request side
    input  wire logic              i_clk,
    input  wire logic              i_slow,
    input  wire tcs_mem_req_t      i_mem,
    // answer side
    output logic                   o_valid,
    output logic      [WORD_W-1:0] o_data
);
    logic [2:0]        wait_reg = 3'h0;
    logic [ADDR_W-1:0] addr_reg = 15'h0000;
    function automatic logic [WORD_W-1:0] table_word(input logic [ADDR_W-1:0] a);
        return {a[5:0] ^ 6'h15, ~a, a + 15'h0040};
    endfunction
    // data lines never keep a stale word, so a late sample cannot pass by luck
    always @(posedge i_clk) begin
        o_valid  <= wait_reg == 3'h1;
        o_data   <= wait_reg == 3'h1 ? table_word(addr_reg) : ~o_data;
        wait_reg <= i_mem.req ? (i_slow ? 3'h5 : 3'h1) : wait_reg - 3'(wait_reg != 3'h0);
        if (i_mem.req) addr_reg <= i_mem.addr;
    end
endmodule

// ---- sim/tcs_sequencer_properties.sv ----
`timescale 1ns/1ns
module tcs_sequencer_properties
    import tcs_pkg::*;
(
    // clock and control
    input wire logic              i_clk,
    input wire logic              i_rst,
    input wire logic              i_ce,
    // command
    input wire logic              i_start,
    input wire tcs_cmd_t          i_cmd,
    input wire logic [ADDR_W-1:0] i_xr_value,
    input wire logic              o_busy,
    input wire logic              o_done,
    // core storage
    input wire tcs_mem_req_t      o_mem,
    input wire logic              i_mem_valid,
    input wire logic [WORD_W-1:0] i_mem_data,
    // results
    input wire logic [WORD_W-1:0] o_accumulator_register,
    input wire logic [WORD_W-1:0] o_multiplier_quotient_register,
    input wire logic [WORD_W-1:0] o_storage_register,
    input wire logic [ADDR_W-1:0] o_eff_addr,
    input wire tcs_xr_write_t     o_xr_write
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst || !i_ce);
    logic              take, ans;
    tcs_op_t           op_reg;
    logic [ADDR_W-1:0] first_reg;
    assign take = i_ce && i_start && !o_busy;
    assign ans  = i_mem_valid && o_busy && !o_mem.req;
    // op in flight kept so each answer is judged by its own convert
    always_ff @(posedge i_clk) begin
        if (take) begin
            op_reg    <= i_cmd.op;
            first_reg <= i_cmd.addr + ADDR_W'(i_cmd.op == TCS_OP_REPLACE_RIGHT ? o_accumulator_register[5:0]
                                              : o_multiplier_quotient_register[35:30]);
        end
    end
    property p_first_req;
        take && i_cmd.op < TCS_OP_TRANSFER_SET && i_cmd.count != 8'h00 |-> ##2 o_mem.req && o_mem.addr == first_reg;
    endproperty
    a_first_req: assert property (p_first_req) else $error("first table address wrong");
    property p_zero; take && i_cmd.op < TCS_OP_TRANSFER_SET && i_cmd.count == 8'h00 |-> ##2 o_done; endproperty
    a_zero: assert property (p_zero) else $error("empty convert did not end");
    property p_busy_req; o_mem.req |-> o_busy; endproperty
    a_busy_req: assert property (p_busy_req) else $error("table request while idle");
    property p_sr; ans |=> o_storage_register == $past(i_mem_data); endproperty
    a_sr: assert property (p_sr) else $error("table word not in storage register");
    property p_left; ans && op_reg == TCS_OP_REPLACE_LEFT |=> o_multiplier_quotient_register ==
        {$past(o_multiplier_quotient_register[29:0]), $past(i_mem_data[35:30])}; endproperty
    a_left: assert property (p_left) else $error("leftward replace wrong");
    property p_right; ans && op_reg == TCS_OP_REPLACE_RIGHT |=> o_accumulator_register ==
        {$past(i_mem_data[35:30]), $past(o_accumulator_register[35:6])}; endproperty
    a_right: assert property (p_right) else $error("rightward replace wrong");
    property p_add; ans && op_reg == TCS_OP_ADD_QUOTIENT |=> o_accumulator_register ==
        $past(o_accumulator_register) + $past(i_mem_data); endproperty
    a_add: assert property (p_add) else $error("add convert sum wrong");
    property p_xr; o_xr_write.we && o_xr_write.sel != XR_LINK |->
        o_xr_write.sel == XR_CONVERT && o_xr_write.value == o_storage_register[14:0]; endproperty
    a_xr: assert property (p_xr) else $error("convert index write wrong");
    property p_link; take && i_cmd.op == TCS_OP_TRANSFER_SET |=> o_xr_write.we && o_xr_write.sel == XR_LINK &&
        o_xr_write.value == -$past(i_cmd.location); endproperty
    a_link: assert property (p_link) else $error("link index write wrong");
    property p_eff; take && i_cmd.op == TCS_OP_EFF_ADDR && i_cmd.tag != 3'h0 |=> o_done &&
        o_eff_addr == $past(i_cmd.addr) - $past(i_xr_value); endproperty
    a_eff: assert property (p_eff) else $error("effective address wrong");
endmodule
bind tcs_sequencer tcs_sequencer_properties tcs_sequencer_properties_inst (
    .i_clk                          (i_clk),
    .i_rst                          (i_rst),
    .i_ce                           (i_ce),
    .i_start                        (i_start),
    .i_cmd                          (i_cmd),
    .i_xr_value                     (i_xr_value),
    .o_busy                         (o_busy),
    .o_done                         (o_done),
    .o_mem                          (o_mem),
    .i_mem_valid                    (i_mem_valid),
    .i_mem_data                     (i_mem_data),
    .o_accumulator_register         (o_accumulator_register),
    .o_multiplier_quotient_register (o_multiplier_quotient_register),
    .o_storage_register             (o_storage_register),
    .o_eff_addr                     (o_eff_addr),
    .o_xr_write                     (o_xr_write)
);

// ---- sim/test_table_convert_sequencer.sv ----
`timescale 1ns/1ns
module test_table_convert_sequencer;
    import tcs_pkg::*;
    logic              i_clk = 1'b0, i_rst = 1'b1, i_ce = 1'b1, i_start = 1'b0, i_load = 1'b0, i_mem_valid;
    logic              o_busy, o_done, slow = 1'b0, poke = 1'b0, we;
    tcs_cmd_t          i_cmd = '0;
    tcs_mem_req_t      o_mem;
    tcs_xr_write_t     o_xr_write;
    logic [ADDR_W-1:0] i_xr_value = '0, o_eff_addr, o_transfer_addr, e_base, ta;
    logic [WORD_W-1:0] i_acc_load = '0, i_mq_load = '0, i_mem_data, e_acc = '0, e_mq = '0, e_sr = '0, w, t;
    logic [WORD_W-1:0] o_accumulator_register, o_multiplier_quotient_register, o_storage_register;
    logic [31:0]       lfsr = 32'h26fc;
    int                mismatches = 0, check_count = 0, i, k;
    tcs_sequencer  tcs_sequencer_inst (
        .i_clk                          (i_clk),
        .i_rst                          (i_rst),
        .i_ce                           (i_ce),
        .i_start                        (i_start),
        .i_cmd                          (i_cmd),
        .i_xr_value                     (i_xr_value),
        .o_busy                         (o_busy),
        .o_done                         (o_done),
        .i_load                         (i_load),
        .i_acc_load                     (i_acc_load),
        .i_mq_load                      (i_mq_load),
        .o_mem                          (o_mem),
        .i_mem_valid                    (i_mem_valid),
        .i_mem_data                     (i_mem_data),
        .o_accumulator_register         (o_accumulator_register),
        .o_multiplier_quotient_register (o_multiplier_quotient_register),
        .o_storage_register             (o_storage_register),
        .o_eff_addr                     (o_eff_addr),
        .o_transfer_addr                (o_transfer_addr),
        .o_xr_write                     (o_xr_write)
    );
    tcs_core_model tcs_core_model_inst (.i_clk(i_clk), .i_slow(slow), .i_mem(o_mem), .o_valid(i_mem_valid),
                                        .o_data(i_mem_data));
    always #50 i_clk = ~i_clk;
    function automatic logic [WORD_W-1:0] r36();
        repeat (11) lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return {lfsr[7:4], lfsr};
    endfunction
    task automatic check(input string what, input logic [WORD_W-1:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic load();
        @(negedge i_clk);
        i_acc_load = r36();
        i_mq_load = r36();
        i_load = 1'b1;
        @(negedge i_clk);
        i_load = 1'b0;
        e_acc = i_acc_load;
        e_mq = i_mq_load;
    endtask
    task automatic run(input tcs_op_t op, input logic [ADDR_W-1:0] a, input logic [2:0] tg, input logic [7:0] n);
        if (n == 8'h00 && tg == 3'h1) tg = 3'h0;
        w = op == TCS_OP_REPLACE_RIGHT ? e_acc : e_mq;
        e_base = a;
        for (k = 0; k < n && op < TCS_OP_TRANSFER_SET; k++) begin
            ta = e_base + ADDR_W'(op == TCS_OP_REPLACE_RIGHT ? w[5:0] : w[35:30]);
            t = tcs_core_model_inst.table_word(ta);
            e_base = t[14:0];
            e_sr = t;
            if (op == TCS_OP_REPLACE_RIGHT) w = {t[35:30], w[35:6]};
            else if (op == TCS_OP_REPLACE_LEFT) w = {w[29:0], t[35:30]};
            else w = {w[29:0], w[35:30]};
            if (op == TCS_OP_ADD_QUOTIENT) e_acc = e_acc + t;
        end
        if (op == TCS_OP_REPLACE_RIGHT) e_acc = w;
        else if (op < TCS_OP_TRANSFER_SET) e_mq = w;
        we = op == TCS_OP_TRANSFER_SET || (op < TCS_OP_TRANSFER_SET && tg == 3'h1);
        i_xr_value = lfsr[30:16];
        i_cmd = {op, a, tg, n, a ^ 15'h5a5a};
        i_start = 1'b1;
        @(negedge i_clk);
        i_start = 1'b0;
        // a stray start and load while busy must both be refused
        for (k = 0; k < 400 && o_done !== 1'b1; k++) begin
            @(negedge i_clk);
            // strobes move only early, so a following start never shares their time step
            if (k == 1 || k == 2) begin
                i_start = poke && k == 1 && n > 8'h01;
                i_load = i_start;
            end
        end
        check("done", o_done, 1'b1);
        check("xr_we", o_xr_write.we, we);
        if (we) check("xr_sel", o_xr_write.sel, op == TCS_OP_TRANSFER_SET ? XR_LINK : XR_CONVERT);
        if (op < TCS_OP_TRANSFER_SET) begin
            check("acc", o_accumulator_register, e_acc);
            check("mq", o_multiplier_quotient_register, e_mq);
            check("sr", o_storage_register, e_sr);
            if (we) check("xr_value", o_xr_write.value, e_base);
        end else begin
            ta = op == TCS_OP_EFF_ADDR ? (tg == 3'h0 ? a : a - i_xr_value) : -(a ^ 15'h5a5a);
            check("address", op == TCS_OP_EFF_ADDR ? o_eff_addr : o_xr_write.value, ta);
            if (op == TCS_OP_TRANSFER_SET) check("transfer", o_transfer_addr, a);
        end
    endtask
    initial begin
        repeat (8) @(negedge i_clk);
        i_rst = 1'b0;
        @(negedge i_clk);
        check("acc_reset", o_accumulator_register, WORD_RESET);
        check("busy_reset", o_busy, 1'b0);
        // every op meets every count 0..7; even passes after pass 0 start in the done cycle
        for (i = 0; i < 40; i++) begin
            if (i[0]) load();
            void'(r36());
            slow = lfsr[9];
            poke = lfsr[10];
            run(tcs_op_t'(i % 5), lfsr[14:0], lfsr[17:15], 8'(i % 8));
        end
        report_and_stop();
    end
    initial begin
        repeat (20000) @(posedge i_clk);
        mismatches++;
        report_and_stop();
    end
endmodule
